// ---- pkg/qdac_consts.svh ----
// qdac_consts.svh: offsets, field positions, reset values and counts
// assumes: included by its bare name from package and design files
`ifndef QDAC_CONSTS_SVH
`define QDAC_CONSTS_SVH

// channel code width and channel count
`define QDAC_CODE_W       10
`define QDAC_NCHAN        4
// fixed upper six address bits; low bit comes from the select pin
`define QDAC_ADDR_HI      6'h1E
// reset values
`define QDAC_CODE_RST     10'h000
`define QDAC_PD_RST       2'h3
// bits per bus word before the acknowledge slot
`define QDAC_WORD_BITS    4'h8
// command field positions in the first data byte
`define QDAC_CMD_MSB      7
`define QDAC_CMD_LSB      4
// extended command value and power-down select positions
`define QDAC_CMD_EXT      4'hF
// power-down select bits sit in the byte after the extended command
`define QDAC_PD_HI_POS    3
`define QDAC_PD_LO_POS    2
// command groups
`define QDAC_CMD_BOTH     2'h0
`define QDAC_CMD_INPUT    2'h1
`define QDAC_CMD_XFER     4'h8
`define QDAC_CMD_XFERB    4'h9

`endif

// ---- pkg/qdac_pkg.sv ----
// qdac_pkg: types for the quad converter two-wire slave
// assumes: qdac_consts.svh is on the include path
`include "qdac_consts.svh"
package qdac_pkg;

  // ===========================================================
  // protocol states, gray coded along address, ack, data path
  typedef enum logic [2:0] {
    QDAC_IDLE  = 3'h0,
    QDAC_ADDR  = 3'h1,
    QDAC_AACK  = 3'h3,
    QDAC_WDATA = 3'h2,
    QDAC_WACK  = 3'h6,
    QDAC_RDATA = 3'h7,
    QDAC_RACK  = 3'h5
  } qdac_state_type;

  // power-down selection
  typedef enum logic [1:0] {
    QDAC_PD_AWAKE = 2'h0,
    QDAC_PD_FLOAT = 2'h1,
    QDAC_PD_1K    = 2'h2,
    QDAC_PD_100K  = 2'h3
  } qdac_pd_type;

endpackage

// ---- hw/qdac_bus_edges.sv ----
// qdac_bus_edges: samples scl/sda and flags edges and bus conditions
// assumes: scl and sda already synchronous to i_clock
`timescale 1ns/1ps
`default_nettype none
module qdac_bus_edges
  import qdac_pkg::*;
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_nrst,
  // bus lines
  input  wire logic i_scl,
  input  wire logic i_sda,
  // decoded events, one-cycle pulses, plus the registered data sample o_sda
  output logic      o_scl_rise,
  output logic      o_scl_fall,
  output logic      o_start,
  output logic      o_stop,
  output logic      o_sda
);

  // ===========================================================
  // state
  typedef struct packed {
    logic scl;
    logic sda;
  } qdac_edge_state_type;

  qdac_edge_state_type r, next_r;

  // next state is just the current samples
  always_comb begin
    next_r     = r;
    next_r.scl = i_scl;
    next_r.sda = i_sda;
  end

  // idle bus reads high on both lines
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      r <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      r <= next_r;
    end
  end

  // edges and conditions
  assign o_scl_rise = i_scl & ~r.scl;
  assign o_scl_fall = ~i_scl & r.scl;
  assign o_start    = i_scl & r.scl & r.sda & ~i_sda;
  assign o_stop     = i_scl & r.scl & ~r.sda & i_sda;
  assign o_sda      = r.sda;

endmodule
`default_nettype wire

// ---- hw/qdac_slave.sv ----
// qdac_slave: two-wire slave and register control of a quad 10-bit converter
// assumes: scl/sda inputs synchronous to i_clock, external open-drain wire
`timescale 1ns/1ps
`default_nettype none
`include "qdac_consts.svh"

// ===========================================================
// Contract
// - address low bit equals the level on the address-select pin.
// - four channels, each an input and a converter register, 10 bits.
// - converter writes update outputs now; input-only writes do not.
// - registers hold their contents while powered, no refresh.
// - codes are straight binary 0 to 1023, output ref times code/1024.
// - power-up clears converter codes, enters 100k power-down.
// - power-down select 00 wake, 01 float, 10 1k, 11 100k.
// - any power-down disables buffers and disconnects strings.
// - registers survive power-down; wake-up restores previous code.
// - slave only, never drives the serial clock.
// - START/STOP framing; 8-bit words plus one acknowledge clock.
// - data line driven only low, open-drain, never high.
// - START is SDA fall with SCL high; STOP is SDA rise.
// - repeated START restarts address reception without idling.
// - after STOP or address mismatch ignore bus until next START.
// - STOP accepted at any bit, not in the START's high pulse.
// - back-to-back writes accepted with or without repeated START.
// - works at any serial clock rate up to 400kHz.
// - last address bit is direction, 0 write, 1 read.
// - acknowledge matching address and every data byte, ninth clock.
// - registers update at ack falling edge; aborted writes change nothing.
// - a read returns two bytes, second after master acknowledges first.
module qdac_slave
  import qdac_pkg::*;
(
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  // two-wire bus; scl is input only since the slave never clocks
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  // address select pin
  input  wire logic       i_addr_sel,
  // converter codes per channel
  output logic [9:0]      o_channel_a_output,
  output logic [9:0]      o_channel_b_output,
  output logic [9:0]      o_channel_c_output,
  output logic [9:0]      o_channel_d_output,
  // per-channel buffer enable and power-down select
  output logic [3:0]      o_buffer_en,
  output logic [3:0]      o_powerdown_select_high,
  output logic [3:0]      o_powerdown_select_low,
  // bus engaged with this slave
  output logic            o_busy
);

  // ===========================================================
  // state record
  typedef struct packed {
    qdac_state_type   st;
    logic [3:0]       bitcnt;
    logic [7:0]       shreg;
    logic             addr_ok;
    logic             rd;
    logic             second;
    logic [7:0]       cmd;
    logic             ext;
    logic             ack_drive;
    logic             sda_low;
    logic             start_hi;
    logic [39:0]      inreg;
    logic [39:0]      dacreg;
    logic [7:0]       pd;
    logic [1:0]       rdch;
  } qdac_core_type;

  qdac_core_type r, next_r;

  // edge detector outputs
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic sda_s;

  // bus oversampled at i_clock, far above any legal bus rate
  qdac_bus_edges u_edges (
    .i_clock    (i_clock),
    .i_nrst     (i_nrst),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall),
    .o_start    (start_c),
    .o_stop     (stop_c),
    .o_sda      (sda_s)
  );

  // ===========================================================
  // helpers
  // own slave address, low bit from the select pin
  function automatic logic [6:0] own_addr(input logic sel);
    own_addr = {`QDAC_ADDR_HI, sel};
  endfunction

  // 10-bit field of a channel out of a packed 4x10 bank
  function automatic logic [9:0] chan(input logic [39:0] bank, input logic [1:0] c);
    chan = bank[c*10 +: 10];
  endfunction

  // ===========================================================
  // next-state logic
  always_comb begin
    logic [9:0] code;
    logic [1:0] ch;
    logic [7:0] nbyte;
    logic [6:0] own;
    logic [9:0] rdc;
    own    = own_addr(i_addr_sel);
    rdc    = chan(r.dacreg, r.rdch);
    code   = '0;
    ch     = '0;
    nbyte  = '0;
    next_r = r;

    if (start_c) begin
      // start or repeated start: restart address reception
      next_r.st        = QDAC_ADDR;
      next_r.bitcnt    = '0;
      next_r.addr_ok   = 1'b1;
      next_r.second    = 1'b0;
      next_r.sda_low   = 1'b0;
      next_r.start_hi  = 1'b1;
    end else if (stop_c && !r.start_hi) begin
      // stop anywhere, but not in the start's own high pulse
      next_r.st      = QDAC_IDLE;
      next_r.sda_low = 1'b0;
    end else begin
      if (scl_fall) begin
        next_r.start_hi = 1'b0;
      end
      case (r.st)
        QDAC_IDLE: begin
          // clock ignored until the next start
          next_r.sda_low = 1'b0;
        end
        QDAC_ADDR: begin
          if (scl_rise) begin
            nbyte          = {r.shreg[6:0], sda_s};
            next_r.shreg   = nbyte;
            next_r.bitcnt  = r.bitcnt + 4'h1;
            // compare bit by bit; a mismatch clears addr_ok, acted on after the eighth bit
            if (r.bitcnt < 4'h7 && sda_s != own[3'h6 - r.bitcnt[2:0]]) begin
              next_r.addr_ok = 1'b0;
            end
            if (r.bitcnt == `QDAC_WORD_BITS - 4'h1) begin
              next_r.rd = sda_s;
            end
          end else if (scl_fall && r.bitcnt == `QDAC_WORD_BITS) begin
            if (r.addr_ok) begin
              next_r.st      = QDAC_AACK;
              next_r.sda_low = 1'b1;
            end else begin
              next_r.st = QDAC_IDLE;
            end
          end
        end
        QDAC_AACK: begin
          // ack held for the whole ninth period; released at its fall on a write, kept low on a read
          if (scl_fall) begin
            next_r.bitcnt = '0;
            if (r.rd) begin
              next_r.st      = QDAC_RDATA;
              next_r.second  = 1'b0;
              next_r.shreg   = {6'h00, rdc[9:8]};
              next_r.sda_low = 1'b1; // first byte leads with zero bits
            end else begin
              next_r.st      = QDAC_WDATA;
              next_r.second  = 1'b0;
              next_r.sda_low = 1'b0;
            end
          end
        end
        QDAC_WDATA: begin
          if (scl_rise) begin
            next_r.shreg  = {r.shreg[6:0], sda_s};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.bitcnt == `QDAC_WORD_BITS) begin
            next_r.st      = QDAC_WACK;
            next_r.sda_low = 1'b1;
          end
        end
        QDAC_WACK: begin
          if (scl_fall) begin
            next_r.st      = QDAC_WDATA;
            next_r.bitcnt  = '0;
            next_r.sda_low = 1'b0;
            if (!r.second) begin
              // first byte of a pair: command plus top code bits
              next_r.cmd    = r.shreg;
              next_r.second = 1'b1;
              next_r.ext    = (r.shreg[`QDAC_CMD_MSB:`QDAC_CMD_LSB] == `QDAC_CMD_EXT)
                              && (r.shreg[3:0] == 4'h0);
              next_r.rdch   = r.shreg[5:4];
            end else begin
              // complete pair: apply on this ack falling edge only
              next_r.second = 1'b0;
              ch   = r.cmd[5:4];
              code = {r.cmd[3:0], r.shreg[7:2]};
              if (r.ext) begin
                // extended: power-down select on chosen channels
                for (int i = 0; i < `QDAC_NCHAN; i++) begin
                  if (r.shreg[4 + i]) begin
                    // mode comes from the second byte; the command bits are fixed
                    next_r.pd[i*2 +: 2] = {r.shreg[`QDAC_PD_HI_POS],
                                           r.shreg[`QDAC_PD_LO_POS]};
                  end
                end
              end else if (r.cmd[7:6] == `QDAC_CMD_BOTH) begin
                // load one channel fully, transfer the others
                next_r.inreg[ch*10 +: 10] = code;
                next_r.dacreg             = r.inreg;
                next_r.dacreg[ch*10 +: 10] = code;
              end else if (r.cmd[7:6] == `QDAC_CMD_INPUT) begin
                next_r.inreg[ch*10 +: 10] = code;
              end else if (r.cmd[7:4] == `QDAC_CMD_XFER
                           || r.cmd[7:4] == `QDAC_CMD_XFERB) begin
                // transfer input registers to converter registers
                next_r.dacreg = r.inreg;
              end else begin
                next_r.dacreg[ch*10 +: 10] = code;
              end
            end
          end
        end
        QDAC_RDATA: begin
          // shift out on scl fall; only low is driven
          if (scl_fall) begin
            if (r.bitcnt == `QDAC_WORD_BITS - 4'h1) begin
              next_r.st      = QDAC_RACK;
              next_r.sda_low = 1'b0;
              next_r.bitcnt  = '0;
            end else begin
              next_r.bitcnt  = r.bitcnt + 4'h1;
              next_r.shreg   = {r.shreg[6:0], 1'b0};
              next_r.sda_low = ~r.shreg[6];
            end
          end
        end
        QDAC_RACK: begin
          // master acknowledge on rise; nack ends reading
          if (scl_rise) begin
            next_r.ack_drive = ~sda_s;
          end else if (scl_fall) begin
            if (r.ack_drive && !r.second) begin
              next_r.st      = QDAC_RDATA;
              next_r.second  = 1'b1;
              next_r.shreg   = rdc[7:0];
              next_r.sda_low = ~rdc[7];
            end else begin
              // further reads need a repeated start
              next_r.st = QDAC_IDLE;
            end
          end
        end
        default: begin
          next_r.st = QDAC_IDLE;
        end
      endcase
    end
  end

  // ===========================================================
  // registers; reset models power-on: codes zero, 100k power-down
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      r         <= '0;
      r.st      <= QDAC_IDLE;
      r.inreg   <= {4{`QDAC_CODE_RST}};
      r.dacreg  <= {4{`QDAC_CODE_RST}};
      r.pd      <= {4{`QDAC_PD_RST}};
    end else begin
      r <= next_r;
    end
  end

  // outputs, registered directly; pd bits kept with the code
  // so wake-up restores the stored value
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_sda                   <= 1'b0;
      o_sda_oe                <= 1'b0;
      o_channel_a_output      <= `QDAC_CODE_RST;
      o_channel_b_output      <= `QDAC_CODE_RST;
      o_channel_c_output      <= `QDAC_CODE_RST;
      o_channel_d_output      <= `QDAC_CODE_RST;
      o_buffer_en             <= 4'h0;
      o_powerdown_select_high <= 4'hF;
      o_powerdown_select_low  <= 4'hF;
      o_busy                  <= 1'b0;
    end else begin
      o_sda    <= 1'b0;
      o_sda_oe <= next_r.sda_low;
      o_channel_a_output <= chan(next_r.dacreg, 2'h0);
      o_channel_b_output <= chan(next_r.dacreg, 2'h1);
      o_channel_c_output <= chan(next_r.dacreg, 2'h2);
      o_channel_d_output <= chan(next_r.dacreg, 2'h3);
      for (int i = 0; i < `QDAC_NCHAN; i++) begin
        o_buffer_en[i]             <= (next_r.pd[i*2 +: 2] == QDAC_PD_AWAKE);
        o_powerdown_select_high[i] <= next_r.pd[i*2 + 1];
        o_powerdown_select_low[i]  <= next_r.pd[i*2];
      end
      o_busy <= (next_r.st != QDAC_IDLE);
    end
  end

endmodule
`default_nettype wire

// ---- sim/qdac_slave_chk.sv ----
// qdac_slave_chk: port assertions for the converter two-wire slave
// assumes: bound onto qdac_slave, bus lines synchronous to i_clock
`timescale 1ns/1ps
`default_nettype none
module qdac_slave_chk (
  // clock and reset
  input wire logic       i_clock,
  input wire logic       i_nrst,
  // bus lines
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda,
  input wire logic       o_sda_oe,
  // outputs under watch
  input wire logic [9:0] o_channel_a_output,
  input wire logic [9:0] o_channel_b_output,
  input wire logic [9:0] o_channel_c_output,
  input wire logic [9:0] o_channel_d_output,
  input wire logic [3:0] o_buffer_en,
  input wire logic [3:0] o_powerdown_select_high,
  input wire logic [3:0] o_powerdown_select_low,
  input wire logic       o_busy
);
  // ===========================================================
  // helpers
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic [39:0] codes;
  assign codes = {o_channel_a_output, o_channel_b_output, o_channel_c_output, o_channel_d_output};
  sequence bus_start; i_scl && i_sda ##1 i_scl && !i_sda; endsequence
  sequence bus_stop; i_scl && !i_sda ##1 i_scl && i_sda; endsequence
  // ===========================================================
  // assertions
  chk_sda_low_only: assert property (o_sda == 1'b0)
    else $error("data line driven high");
  chk_reset_values: assert property (disable iff (1'b0) !i_nrst |=> codes == 40'h0
    && (o_powerdown_select_high & o_powerdown_select_low) == 4'hF && o_buffer_en == 4'h0)
    else $error("reset state wrong");
  chk_buffer_mode: assert property (o_buffer_en == ~(o_powerdown_select_high | o_powerdown_select_low))
    else $error("buffer enable disagrees with mode");
  chk_ack_scl_low: assert property ($rose(o_sda_oe) |-> !i_scl)
    else $error("data pulled while clock high");
  chk_ack_stands: assert property ($rose(o_sda_oe) |-> o_sda_oe [*4])
    else $error("pull-down too short");
  chk_drive_busy: assert property (o_sda_oe |-> o_busy)
    else $error("driving while idle");
  chk_codes_idle: assert property (!o_busy && !$past(o_busy) |-> $stable(codes))
    else $error("codes moved while idle");
  chk_codes_scl_low: assert property (!$stable(codes) |-> !i_scl)
    else $error("codes moved with clock high");
  chk_start_busy: assert property (bus_start |-> ##[1:6] o_busy)
    else $error("start not seen");
  chk_stop_idle: assert property (bus_stop |-> ##[1:6] !o_busy)
    else $error("stop not seen");
endmodule
bind qdac_slave qdac_slave_chk chk_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_channel_a_output(o_channel_a_output),
  .o_channel_b_output(o_channel_b_output), .o_channel_c_output(o_channel_c_output),
  .o_channel_d_output(o_channel_d_output), .o_buffer_en(o_buffer_en),
  .o_powerdown_select_high(o_powerdown_select_high),
  .o_powerdown_select_low(o_powerdown_select_low), .o_busy(o_busy));
`default_nettype wire

// ---- sim/qdac_master_model.sv ----
// qdac_master_model: behavioural bus master with start, stop and byte tasks
// assumes: i_sda is the resolved wire; phases of four clocks keep the slave's minimum
`timescale 1ns/1ps
`default_nettype none
module qdac_master_model (
  // clock and resolved data
  input  wire logic i_clock,
  input  wire logic i_sda,
  // driven lines, 1 means released
  output logic      o_scl,
  output logic      o_sda
);
  localparam int PH = 4;
  // idle bus: both released
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // one phase, changes land on the falling edge; bus rate well inside
  task automatic tick();
    repeat (PH) @(negedge i_clock);
  endtask
  // start or repeated start; after a stop, data stays high three phases before its fall
  task automatic start();
    o_sda = 1'b1;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda = 1'b0;
    tick();
    o_scl = 1'b0;
    tick();
  endtask
  task automatic stop();
    o_sda = 1'b0;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda = 1'b1;
    tick();
  endtask
  // data moves only with clock low
  task automatic bitx(input logic b, output logic r);
    o_sda = b;
    tick();
    o_scl = 1'b1;
    tick();
    r = i_sda;
    o_scl = 1'b0;
    tick();
  endtask
  // eight bits then the acknowledge slot
  task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
    bitx(last, ack);
  endtask
endmodule
`default_nettype wire

// ---- sim/qdac_slave_tb.sv ----
// qdac_slave_tb: self-checking bench for the converter two-wire slave
// assumes: qdac_master_model drives the bus, a pull-up resolves data
`timescale 1ns/1ps
`default_nettype none
`include "qdac_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module qdac_slave_tb;
  logic        i_clock    = 1'b0;
  logic        i_nrst     = 1'b0;
  logic        i_addr_sel = 1'b0;
  logic        scl, m_sda, sda_w, o_sda, o_sda_oe, o_busy;
  logic [9:0]  ch_a, ch_b, ch_c, ch_d, in_r [4], dac_r [4];
  logic [3:0]  o_buffer_en, pd_hi, pd_lo;
  logic [39:0] codes;
  int          checks, miscompares;
  // pull-up wire: any pull-down wins
  assign sda_w = m_sda & ~o_sda_oe;
  assign codes = {ch_a, ch_b, ch_c, ch_d};
  always #2 i_clock = ~i_clock;
  qdac_master_model mst_u (.i_clock(i_clock), .i_sda(sda_w), .o_scl(scl), .o_sda(m_sda));
  qdac_slave dut_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda_w),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_addr_sel(i_addr_sel), .o_channel_a_output(ch_a),
    .o_channel_b_output(ch_b), .o_channel_c_output(ch_c), .o_channel_d_output(ch_d),
    .o_buffer_en(o_buffer_en), .o_powerdown_select_high(pd_hi),
    .o_powerdown_select_low(pd_lo), .o_busy(o_busy));
  // ===========================================================
  // expectation model
  function automatic void apply(input logic [3:0] c, input logic [9:0] d);
    if (c[3:2] == 2'h0) begin
      in_r[c[1:0]] = d;
      dac_r = in_r;
    end else if (c[3:2] == 2'h1) begin
      in_r[c[1:0]] = d;
    end else if (c[3:1] == 3'h4) begin
      dac_r = in_r;
    end else begin
      dac_r[c[1:0]] = d;
    end
  endfunction
  function automatic logic [39:0] exp_codes();
    return {dac_r[0], dac_r[1], dac_r[2], dac_r[3]};
  endfunction
  function automatic logic [7:0] adr(input logic rd);
    return {`QDAC_ADDR_HI, i_addr_sel, rd};
  endfunction
  // ===========================================================
  // bus helpers and closing
  task automatic wr(input logic [3:0] c, input logic [9:0] d, output logic a);
    logic [7:0] r;
    logic       a1;
    mst_u.xfer({c, d[9:6]}, 1'b1, r, a1);
    mst_u.xfer({d[5:0], 2'b00}, 1'b1, r, a);
    a = a | a1;
  endtask
  task automatic results();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog, a few times the expected run
  initial begin
    repeat (20000) @(posedge i_clock);
    miscompares++;
    results();
  end
  // ===========================================================
  // main sequence
  initial begin
    logic [7:0] r, r2;
    logic       a;
    logic [3:0] c;
    logic [9:0] d;
    void'($urandom(78));
    i_addr_sel = 1'($urandom_range(0, 1));
    for (int i = 0; i < 4; i++) begin
      in_r[i] = 10'h000;
      dac_r[i] = 10'h000;
    end
    repeat (6) @(negedge i_clock);
    i_nrst = 1'b1;
    repeat (2) @(negedge i_clock);
    `CHK(codes, 40'h0)
    `CHK(pd_hi & pd_lo, 4'hF)
    $display("test reset done");
    // foreign address, data that follows must be ignored
    mst_u.start();
    mst_u.xfer(adr(1'b0) ^ 8'h02, 1'b1, r, a);
    `CHK(a, 1'b1)
    `CHK(o_busy, 1'b0)
    wr(4'h0, 10'h155, a);
    mst_u.stop();
    `CHK(codes, exp_codes())
    $display("test mismatch done");
    // commands 0 to 9 plus random ones up to 14, boundary codes, repeated start without stop
    for (int n = 0; n < 16; n++) begin
      if (n % 5 == 0) begin
        mst_u.start();
        mst_u.xfer(adr(1'b0), 1'b1, r, a);
        `CHK(a, 1'b0)
      end
      c = (n < 10) ? 4'(n) : 4'($urandom_range(0, 14));
      if (n == 15) c = 4'($urandom_range(0, 3));
      d = (n == 0) ? 10'h3FF : (n == 1) ? 10'h000 : 10'($urandom_range(0, 1023));
      wr(c, d, a);
      apply(c, d);
      `CHK(a, 1'b0)
      `CHK(codes, exp_codes())
    end
    mst_u.stop();
    $display("test write done");
    // two reads, each opened by its own start
    for (int k = 0; k < 2; k++) begin
      mst_u.start();
      mst_u.xfer(adr(1'b1), 1'b1, r, a);
      `CHK(a, 1'b0)
      mst_u.xfer(8'hFF, 1'b0, r, a);
      mst_u.xfer(8'hFF, 1'b1, r2, a);
      `CHK({r, r2}, {6'h00, dac_r[c[1:0]]})
    end
    mst_u.stop();
    $display("test read done");
    // stop in mid-byte after a lone command byte
    mst_u.start();
    mst_u.xfer(adr(1'b0), 1'b1, r, a);
    mst_u.xfer(8'h0A, 1'b1, r, a);
    mst_u.bitx(1'b1, a);
    mst_u.bitx(1'b0, a);
    mst_u.stop();
    `CHK(codes, exp_codes())
    $display("test abort done");
    // extended command, all channels to the 100k mode
    mst_u.start();
    mst_u.xfer(adr(1'b0), 1'b1, r, a);
    mst_u.xfer(8'hF0, 1'b1, r, a);
    mst_u.xfer(8'hFC, 1'b1, r, a);
    mst_u.stop();
    `CHK(pd_hi & pd_lo, 4'hF)
    `CHK(o_buffer_en, 4'h0)
    `CHK(codes, exp_codes())
    // wake channels a and c, then a random mode on channel b
    mst_u.start();
    mst_u.xfer(adr(1'b0), 1'b1, r, a);
    mst_u.xfer(8'hF0, 1'b1, r, a);
    mst_u.xfer(8'h50, 1'b1, r, a);
    c = 4'($urandom_range(0, 3));
    mst_u.xfer(8'hF0, 1'b1, r, a);
    mst_u.xfer({4'h2, c[1:0], 2'b00}, 1'b1, r, a);
    mst_u.stop();
    `CHK(o_buffer_en, {1'b0, 1'b1, c[1:0] == 2'h0, 1'b1})
    `CHK(pd_hi, {1'b1, 1'b0, c[1], 1'b0})
    `CHK(pd_lo, {1'b1, 1'b0, c[0], 1'b0})
    `CHK(codes, exp_codes())
    $display("test powerdown done");
    results();
  end
endmodule
`default_nettype wire
